/* hw/vdram_access_sequencer.sv */
// Control logic for instruction fetch through a video DRAM serial port
// and single data reads and writes through its random-access port.
// Assumes all inputs are synchronous to clk and that the refresh
// counter, address decode and write-enable logic sit outside.
//
// Function
// R1: Data access starts the cycle after an idle data_go without bus_invalid.
// R2: Data states two to four follow state one, then the chain clears.
// R3: Precharge lasts three cycles using precharge_first and precharge_second.
// R4: Precharge starts after the third cycle of any access sequence.
// R5: CAS stays active past RAS during a data read.
// R6: load_bank_select loads addr_word_bit into bank_select_bit next edge.
// R7: load_bank_select is instr_request and not instr_state_1.
// R8: bank_select_bit toggles for each further instruction word.
// R9: bank_select_bit holds whenever bus_invalid is high; the code still loads it when load_bank_select is high.
// R10: One shift clock rising edge precedes the first serial word.
// R11: Instruction states three and four force first shifts; bursts later.
// R12: Even bank address passes through or increments by one word.
// R13: latched_word_bit is captured at data start and selects the bank.
// R14: burst_advance_enable is not state one, delayed request and ack.
// R15: Transfer gate held at RAS edge gives a row transfer cycle.
// R16: Transfer gate rises with instr_request and holds until tap fires.
// R17: Strap selects short or long tap; low selects the long tap.
// R18: Transfer gate enables data output in state two of a read.
// R19: Shift clock held low while state one is on and four off.
// R20: After first access the shift clock follows bank_select_bit.
// R21: During reset the shift clock passes the processor clock.
// R22: Ready asserts in the first-word cycle, state three low, four high.
// R23: Ready asserts after a valid burst request and ack last cycle.
// R24: instr_go accepted only when idle and for a valid request.
// R25: instr_state_1 lasts five cycles; fifth is state three low, four high.
// R26: RAS stays active three cycles after any start.
// R27: Registered equations are flops; plain equations are combinational.
// R28: Reset clears all sequence and bank state to idle.
//
// Implementation choices: register access over Wishbone and the address map.
`include "vdram_seq_defs.svh"

module vdram_access_sequencer #(
   parameter int ADDR_W = `VSEQ_ADDR_W,
   parameter int WB_ADR_W = `VSEQ_WB_ADR_W
) (
   input wire logic clk, // Processor clock, 100 MHz.
   input wire logic rst_b, // Synchronous reset, active low.
   input wire logic ce, // Clock enable; sequencer state freezes while low, the register bus does not.
   input wire logic instr_request, // Processor instruction request.
   input wire logic instr_go, // Validated instruction start request.
   input wire logic data_go, // Validated data start request.
   input wire logic data_write, // High for a data write access.
   input wire logic bus_invalid, // Bus control signals not valid.
   input wire logic refresh_busy, // Refresh pending or running.
   input wire logic refresh_last, // Last cycle of a refresh sequence.
   input wire logic instr_burst_request, // Processor burst request.
   input wire logic instr_burst_ack, // System burst acknowledge.
   input wire logic addr_word_bit, // Address bit selecting word bank.
   input wire logic [ADDR_W-1:0] addr_in, // Word address above that bit.
   input wire logic delay_tap_short, // Short delay tap of RAS copy.
   input wire logic delay_tap_long, // Long delay tap of RAS copy.
   input wire logic memory_variant_strap, // Low selects the long tap.
   input wire logic wb_cyc_i, // Wishbone cycle.
   input wire logic wb_stb_i, // Wishbone strobe.
   input wire logic wb_we_i, // Wishbone write enable.
   input wire logic [WB_ADR_W-1:0] wb_adr_i, // Wishbone byte address.
   input wire logic [3:0] wb_sel_i, // Wishbone byte lanes.
   input wire logic [31:0] wb_dat_i, // Wishbone write data.
   output logic [31:0] wb_dat_o, // Wishbone read data.
   output logic wb_ack_o, // Wishbone acknowledge.
   output logic ras_strobe, // Row strobe, active high.
   output logic cas_strobe, // Column strobe, active high.
   output logic precharge_first, // First precharge flag.
   output logic precharge_second, // Second precharge flag.
   output logic bank_select_bit, // Bank that drives the bus.
   output logic latched_word_bit, // Data bank held for the access.
   output logic load_bank_select, // Bank select load enable.
   output logic burst_advance_enable, // Bank toggle enable for bursts.
   output logic row_copy_and_output_gate, // Transfer and output gate.
   output logic [1:0] serial_shift_clock, // Shift clock per bank.
   output logic instr_ready_resp, // Instruction data valid.
   output logic [ADDR_W-1:0] even_bank_addr // Address for the even bank.
);

   // Refuse widths the logic cannot serve.
   if (ADDR_W < 2 || WB_ADR_W < 3 || WB_ADR_W > 32)
   begin : g_bad_param
      $error("vdram_access_sequencer: unsupported width parameter");
   end

   // Sequence chains and delayed bus copies.
   vdram_seq_pkg::seq_chain_t instr_state;
   vdram_seq_pkg::seq_chain_t data_state;
   logic burst_request_delayed;
   logic instr_ack_delayed;
   logic bus_invalid_delayed;
   logic gate_hold;
   logic [`VSEQ_CTRL_W-1:0] ctrl;

   // Named views of the chains.
   wire instr_state_1 = instr_state[0];
   wire instr_state_2 = instr_state[1];
   wire instr_state_3 = instr_state[2];
   wire instr_state_4 = instr_state[3];
   wire data_state_1 = data_state[0];
   wire data_state_2 = data_state[1];
   wire data_state_3 = data_state[2];
   wire data_state_4 = data_state[3];

   // Idle and start qualification.
   wire idle = !instr_state_1 && !data_state_1 && !precharge_first
      && !precharge_second && !refresh_busy;
   wire instr_start = idle && instr_go && instr_request; // [R24]
   wire data_start = idle && data_go && !instr_go;
   wire first_word_state = !instr_state_3 && instr_state_4; // [R25]

   // Next values of the instruction chain.
   wire next_instr_1 = (!bus_invalid && !instr_state_1 && instr_start)
      || (instr_state_1 && !first_word_state); // [R25]
   wire next_instr_2 = instr_state_1 && !first_word_state;
   wire next_instr_3 = instr_state_2 && !instr_state_4;
   wire next_instr_4 = instr_state_3;

   // Next values of the data chain.
   wire next_data_1 = (!bus_invalid && !data_state_1 && data_start)
      || (data_state_1 && !data_state_4); // [R1]
   wire next_data_2 = data_state_1 && !data_state_4; // [R2]
   wire next_data_3 = data_state_2 && !data_state_4; // [R2]
   wire next_data_4 = data_state_3 && !data_state_4; // [R2]

   // Precharge begins after the third cycle of any access or the last refresh cycle.
   wire next_pre_1 = (!precharge_first
      && (instr_state_3 || data_state_3 || refresh_last))
      || (precharge_first && !precharge_second); // [R3] [R4]

   // Row strobe held for three cycles after a valid start.
   wire next_ras = (!bus_invalid && !ras_strobe
      && (instr_start || data_start))
      || (ras_strobe && instr_state_1 && !instr_state_3)
      || (ras_strobe && data_state_1 && !data_state_3); // [R26]

   // Column strobe follows row strobe, held through a data read.
   wire next_cas = (ras_strobe && (instr_state_1 || data_state_1))
      || (cas_strobe && data_state_1 && !data_write); // [R5]

   // Bank select load, burst enable and ready are combinational.
   wire load_sel = instr_request && !instr_state_1; // [R7]
   wire burst_en = !instr_state_1 && burst_request_delayed
      && instr_ack_delayed; // [R14]
   wire toggle_bank = instr_state_3 || instr_state_4
      || burst_en; // [R8] [R11]
   wire next_bank = load_sel ? addr_word_bit
      : bus_invalid ? bank_select_bit
      : toggle_bank ? !bank_select_bit : bank_select_bit; // [R6] [R9]

   // Tap choice: software override or the strap pin.
   wire variant_short = ctrl[`VSEQ_CTRL_OVERRIDE]
      ? ctrl[`VSEQ_CTRL_VARIANT] : memory_variant_strap;
   wire tap_fired = variant_short ? delay_tap_short
      : delay_tap_long; // [R17]
   wire gate_now = (!data_state_1
      && (instr_request || (gate_hold && !tap_fired)))
      || (data_state_2 && !data_write); // [R15] [R16] [R18]

   // Shift clock low window before the first shift edge.
   wire shift_hold = instr_state_1 && !instr_state_4; // [R19]

   // Selective one-word increment for the even bank.
   wire [ADDR_W-1:0] addr_step = {{(ADDR_W-1){1'b0}}, addr_word_bit};
   wire [ADDR_W-1:0] next_even = addr_in + addr_step; // [R12]

   // Register bus decode.
   wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire [7:0] wb_ofs = 8'(wb_adr_i);
   wire vdram_seq_pkg::reg_sel_t sel_ctrl_v = vdram_seq_pkg::SEL_CTRL;
   wire [1:0] reg_sel = (wb_ofs == `VSEQ_CTRL_OFS) ? 2'(sel_ctrl_v)
      : (wb_ofs == `VSEQ_STATUS_OFS) ? 2'(vdram_seq_pkg::SEL_STATUS)
      : 2'h0;
   wire ctrl_wr = wb_req && wb_we_i && wb_sel_i[0]
      && reg_sel == 2'(vdram_seq_pkg::SEL_CTRL);
   wire [`VSEQ_ST_W-1:0] status_word = {cas_strobe, ras_strobe,
      latched_word_bit, bank_select_bit, precharge_second,
      precharge_first, data_state, instr_state};
   wire [31:0] read_word = (reg_sel == 2'(vdram_seq_pkg::SEL_CTRL))
      ? {{(32-`VSEQ_CTRL_W){1'b0}}, ctrl}
      : (reg_sel == 2'(vdram_seq_pkg::SEL_STATUS))
      ? {{(32-`VSEQ_ST_W){1'b0}}, status_word} : 32'h0;

   // Access and precharge chains.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         instr_state <= 4'h0; // [R28]
         data_state <= 4'h0;
         precharge_first <= 1'b0;
         precharge_second <= 1'b0;
      end
      else if (ce)
      begin
         instr_state <= {next_instr_4, next_instr_3, next_instr_2,
            next_instr_1}; // [R27]
         data_state <= {next_data_4, next_data_3, next_data_2,
            next_data_1};
         precharge_first <= next_pre_1;
         precharge_second <= precharge_first; // [R3]
      end
   end

   // Strobes, bank state and delayed bus copies.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         ras_strobe <= 1'b0;
         cas_strobe <= 1'b0;
         bank_select_bit <= 1'b0;
         latched_word_bit <= 1'b0;
         burst_request_delayed <= 1'b0;
         instr_ack_delayed <= 1'b0;
         bus_invalid_delayed <= 1'b0;
         gate_hold <= 1'b0;
      end
      else if (ce)
      begin
         ras_strobe <= next_ras;
         cas_strobe <= next_cas;
         bank_select_bit <= next_bank;
         if (data_start)
         begin
            latched_word_bit <= addr_word_bit; // [R13]
         end
         burst_request_delayed <= instr_burst_request;
         instr_ack_delayed <= instr_burst_ack;
         bus_invalid_delayed <= bus_invalid;
         gate_hold <= gate_now; // [R16]
      end
   end

   // Control register and bus answer; unmapped reads return zero.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         ctrl <= `VSEQ_CTRL_RESET;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? read_word : 32'h0;
         if (ctrl_wr)
         begin
            ctrl <= wb_dat_i[`VSEQ_CTRL_W-1:0];
         end
      end
   end

   // Combinational responses that must act within the cycle.
   assign load_bank_select = load_sel; // [R7]
   assign burst_advance_enable = burst_en; // [R14]
   assign row_copy_and_output_gate = gate_now; // [R15]
   assign instr_ready_resp = first_word_state
      || (!bus_invalid_delayed && burst_en); // [R22] [R23]
   assign even_bank_addr = next_even; // [R12]

   // Per-bank shift clock: bank 1 follows the bank bit, bank 0 its inverse.
   for (genvar b = 0; b < 2; b++)
   begin : g_shift
      wire bank_match = (b == 1) ? bank_select_bit : !bank_select_bit;
      assign serial_shift_clock[b] = (!rst_b && clk)
         || (rst_b && !shift_hold && bank_match); // [R10] [R20] [R21]
   end

   // Data start leads to state one next cycle.
   a_data_start: assert property (@(posedge clk) // [R1]
      disable iff (!rst_b)
      (ce && data_start && !bus_invalid) |=> data_state_1)
      else $error("data start did not set state one");

   // Data chain steps to state two while it runs.
   a_data_chain: assert property (@(posedge clk) // [R2]
      disable iff (!rst_b)
      (ce && data_state_1 && !data_state_4) |=> data_state_2)
      else $error("data chain did not advance");

   // Data chain clears after state four.
   a_data_clear: assert property (@(posedge clk) // [R2]
      disable iff (!rst_b)
      (ce && data_state_4) |=> !data_state_1 && !data_state_4)
      else $error("data chain did not clear");

   // Precharge second follows first by one cycle.
   a_pre_follow: assert property (@(posedge clk) // [R3]
      disable iff (!rst_b)
      ce |=> precharge_second == $past(precharge_first))
      else $error("precharge second out of step");

   // Precharge starts after instruction state three.
   a_pre_start: assert property (@(posedge clk) // [R4]
      disable iff (!rst_b)
      (ce && instr_state_3 && !precharge_first) |=> precharge_first)
      else $error("precharge did not start");

   // A read keeps the column strobe on while its data chain runs.
   a_cas_hold: assert property (@(posedge clk) // [R5]
      disable iff (!rst_b)
      (ce && cas_strobe && data_state_1 && !data_write) |=> cas_strobe)
      else $error("column strobe dropped during read");

   // Load captures the word bit.
   a_bank_load: assert property (@(posedge clk) // [R6]
      disable iff (!rst_b)
      (ce && load_bank_select) |=>
      bank_select_bit == $past(addr_word_bit))
      else $error("bank select not loaded");

   // Bus invalid freezes the bank bit unless loading.
   a_bank_hold: assert property (@(posedge clk) // [R9]
      disable iff (!rst_b)
      (ce && bus_invalid && !load_bank_select) |=>
      $stable(bank_select_bit))
      else $error("bank select changed while bus invalid");

   // Burst toggles the bank bit.
   a_bank_toggle: assert property (@(posedge clk) // [R8]
      disable iff (!rst_b)
      (ce && burst_advance_enable && !bus_invalid
      && !load_bank_select) |=> bank_select_bit != $past(bank_select_bit))
      else $error("bank select did not toggle");

   // Even word addresses pass unchanged to the even bank.
   a_even_pass: assert property (@(posedge clk) // [R12]
      disable iff (!rst_b)
      !addr_word_bit |-> even_bank_addr == addr_in)
      else $error("even bank address changed for even word");

   // A data start latches the word bit for the whole access.
   a_word_latch: assert property (@(posedge clk) // [R13]
      disable iff (!rst_b)
      (ce && data_start) |=> latched_word_bit == $past(addr_word_bit))
      else $error("word bit not latched at data start");

   // Ready in the fifth instruction cycle.
   a_ready_first: assert property (@(posedge clk) // [R22]
      disable iff (!rst_b)
      first_word_state |-> instr_ready_resp)
      else $error("ready missing in first-word cycle");

   // A valid burst step gives ready in the next cycle after the first word.
   a_ready_burst: assert property (@(posedge clk) // [R23]
      disable iff (!rst_b)
      (ce && instr_burst_request && instr_burst_ack && !bus_invalid)
      |=> instr_state_1 || instr_ready_resp)
      else $error("ready missing after burst step");

   // Shift clocks low during the hold window.
   a_shift_low: assert property (@(posedge clk) // [R19]
      disable iff (!rst_b)
      shift_hold |-> serial_shift_clock == 2'h0)
      else $error("shift clock high during hold");

   // During reset both shift clocks copy the high clock phase.
   a_shift_reset: assert property (@(negedge clk) // [R21]
      !rst_b |-> serial_shift_clock == 2'h3)
      else $error("shift clock not following clock in reset");

   // Row strobe lasts exactly three cycles after an instruction start.
   a_ras_width: assert property (@(posedge clk) // [R26]
      disable iff (!rst_b)
      (ce && instr_start && !bus_invalid && !ras_strobe) ##1 ce [*4]
      |-> !ras_strobe && $past(ras_strobe) && $past(ras_strobe, 2)
      && $past(ras_strobe, 3))
      else $error("row strobe width wrong");

   // Gate drops in the cycle the tap fires outside a data access.
   a_gate_end: assert property (@(posedge clk) // [R17]
      disable iff (!rst_b)
      (!data_state_1 && !instr_request && tap_fired) |->
      !row_copy_and_output_gate)
      else $error("transfer gate held past tap");

   // Reset leaves the sequencer idle with no strobes and no ready.
   a_reset_idle: assert property (@(posedge clk) // [R28]
      !rst_b |=> !ras_strobe && !cas_strobe && !instr_state_1
      && !data_state_1 && !precharge_first && !instr_ready_resp)
      else $error("sequencer not idle after reset");

endmodule // vdram_access_sequencer

/* inc/vdram_seq_defs.svh */
// Constants for the video DRAM access sequencer: register map, field
// positions and reset values. Assumes a 32-bit classic Wishbone slave.
`ifndef VDRAM_SEQ_DEFS_SVH
`define VDRAM_SEQ_DEFS_SVH
// Register byte offsets.
`define VSEQ_CTRL_OFS 8'h00
`define VSEQ_STATUS_OFS 8'h04
// Control fields.
`define VSEQ_CTRL_VARIANT 0
`define VSEQ_CTRL_OVERRIDE 1
`define VSEQ_CTRL_W 2
`define VSEQ_CTRL_RESET 2'h0
// Status fields: sequence bits in the low byte; precharge, bank and strobe bits above.
`define VSEQ_ST_INSTR 0
`define VSEQ_ST_DATA 4
`define VSEQ_ST_PRE1 8
`define VSEQ_ST_PRE2 9
`define VSEQ_ST_BANK 10
`define VSEQ_ST_LATCH 11
`define VSEQ_ST_RAS 12
`define VSEQ_ST_CAS 13
`define VSEQ_ST_W 14
// Default widths.
`define VSEQ_ADDR_W 16
`define VSEQ_WB_ADR_W 8
`endif

/* inc/vdram_seq_pkg.sv */
// Types shared by the video DRAM access sequencer.
// Assumes the constants header is compiled alongside.
package vdram_seq_pkg;
   // One-hot register select decoded from the bus address.
   typedef enum logic [1:0] {
      SEL_CTRL = 2'b01,
      SEL_STATUS = 2'b10
   } reg_sel_t;
   // Four-bit shift chain that counts the access cycles.
   typedef logic [3:0] seq_chain_t;
endpackage

/* tb/vdram_access_sequencer_tb_top.sv */
// Self-checking bench for the video DRAM access sequencer.
// Assumes the design, its header and the far-side model are compiled first.
module vdram_access_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_b = 1'b0;
   logic instr_request = 1'b0, instr_go = 1'b0, data_go = 1'b0;
   logic data_write = 1'b0, bus_invalid = 1'b0, addr_word_bit = 1'b0;
   logic refresh_busy = 1'b0, refresh_last = 1'b0, memory_variant_strap = 1'b0;
   logic instr_burst_request = 1'b0, instr_burst_ack = 1'b0;
   logic [15:0] addr_in = 16'h0000;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic wb_ack_o, ras_strobe, cas_strobe, precharge_first, precharge_second;
   logic bank_select_bit, latched_word_bit, load_bank_select, instr_ready_resp;
   logic burst_advance_enable, row_copy_and_output_gate, tap_s, tap_l;
   logic [1:0] serial_shift_clock;
   logic [15:0] even_bank_addr;
   int miscompares = 0, checks_done = 0;
   always #5 clk = ~clk;
   vdram_access_sequencer i_dut (.clk(clk), .rst_b(rst_b), .ce(1'b1),
      .instr_request(instr_request), .instr_go(instr_go), .data_go(data_go),
      .data_write(data_write), .bus_invalid(bus_invalid),
      .refresh_busy(refresh_busy), .refresh_last(refresh_last),
      .instr_burst_request(instr_burst_request),
      .instr_burst_ack(instr_burst_ack), .addr_word_bit(addr_word_bit),
      .addr_in(addr_in), .delay_tap_short(tap_s), .delay_tap_long(tap_l),
      .memory_variant_strap(memory_variant_strap),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .ras_strobe(ras_strobe), .cas_strobe(cas_strobe),
      .precharge_first(precharge_first), .precharge_second(precharge_second),
      .bank_select_bit(bank_select_bit), .latched_word_bit(latched_word_bit),
      .load_bank_select(load_bank_select),
      .burst_advance_enable(burst_advance_enable),
      .row_copy_and_output_gate(row_copy_and_output_gate),
      .serial_shift_clock(serial_shift_clock),
      .instr_ready_resp(instr_ready_resp), .even_bank_addr(even_bank_addr));
   vdram_far_side i_far (.clk(clk), .rst_b(rst_b), .ras_strobe(ras_strobe),
      .delay_tap_short(tap_s), .delay_tap_long(tap_l));
   // Compares a seen value with the expected one and counts both outcomes.
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Prints the verdict and ends the run.
   task automatic wrap_up();
      if (miscompares == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // One classic Wishbone cycle; holds the request until ack is sampled.
   task automatic wb_cycle(input logic we, input logic [7:0] adr,
                           input logic [31:0] wd, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      wb_sel_i <= 4'hf;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 20)
         check("wb_ack_o", 32'h0, 32'h1);
   endtask
   // Shift clocks follow the processor clock in both phases during reset.
   task automatic t_reset();
      repeat (2)
      begin
         @(posedge clk);
         #1 check("ssc_hi", serial_shift_clock, 2'b11);
         #5 check("ssc_lo", serial_shift_clock, 2'b00);
      end
   endtask
   // Register reset values, a write and read back, an unmapped place.
   task automatic t_regs();
      wb_cycle(1'b0, 8'h00, 32'h0, rd);
      check("ctrl_rst", rd, 32'h0);
      wb_cycle(1'b1, 8'h00, 32'h1, rd);
      wb_cycle(1'b0, 8'h00, 32'h0, rd);
      check("ctrl_wr", rd, 32'h1);
      wb_cycle(1'b1, 8'h00, 32'h0, rd);
      wb_cycle(1'b0, 8'h04, 32'h0, rd);
      check("status_idle", rd, 32'h0);
      wb_cycle(1'b0, 8'h40, 32'h0, rd);
      check("unmapped", rd, 32'h0);
   endtask
   // Even bank address passes or steps by one word, wrapping at the top.
   task automatic t_addr();
      logic [16:0] tbl [3] = '{17'h100ff, 17'h1ffff, 17'h01234};
      foreach (tbl[i])
      begin
         @(posedge clk);
         addr_in <= tbl[i][15:0];
         addr_word_bit <= tbl[i][16];
         @(negedge clk);
         check("even_addr", even_bank_addr,
               16'(tbl[i][15:0] + tbl[i][16]));
      end
   endtask
   // Instruction start and first-word timing, then the gate release
   // on the tap that the strap value s selects.
   task automatic t_instr(input logic s);
      @(posedge clk);
      memory_variant_strap <= s;
      instr_request <= 1'b1;
      instr_go <= 1'b1;
      addr_word_bit <= 1'b1;
      @(negedge clk);
      check("load_c0", load_bank_select, 1'b1);
      check("gate_c0", row_copy_and_output_gate, 1'b1);
      for (int c = 1; c <= 12; c++)
      begin
         @(posedge clk);
         instr_go <= 1'b0;
         instr_request <= 1'b0;
         addr_word_bit <= 1'b0;
         @(negedge clk);
         check("ras", ras_strobe, c <= 3);
         check("pc1", precharge_first, c == 4 || c == 5);
         check("pc2", precharge_second, c == 5 || c == 6);
         check("ready", instr_ready_resp, c == 5);
         if (c == 1)
            check("bank_load", bank_select_bit, 1'b1);
         if (c <= 3)
            check("ssc_low", serial_shift_clock, 2'b00);
         if (c >= 4 && c <= 6)
            check("ssc_bank", serial_shift_clock,
                  {c == 5, c != 5});
         if (c >= 10)
            check("gate_tap", row_copy_and_output_gate,
                  c == 10 && !s);
      end
   endtask
   // One burst step after the first word, with or without an invalid bus.
   task automatic t_burst(input logic inv);
      logic b;
      @(posedge clk);
      bus_invalid <= inv;
      instr_burst_request <= 1'b1;
      instr_burst_ack <= 1'b1;
      @(posedge clk);
      instr_burst_request <= 1'b0;
      instr_burst_ack <= 1'b0;
      @(negedge clk);
      b = bank_select_bit;
      check("advance", burst_advance_enable, 1'b1);
      check("burst_ready", instr_ready_resp, !inv);
      @(posedge clk);
      bus_invalid <= 1'b0;
      @(negedge clk);
      check("bank_step", bank_select_bit, inv ? b : !b);
   endtask
   // Data access; an instruction start arriving mid-access is refused.
   task automatic t_data(input logic we);
      @(posedge clk);
      data_go <= 1'b1;
      data_write <= we;
      addr_word_bit <= 1'b1;
      for (int c = 1; c <= 8; c++)
      begin
         @(posedge clk);
         data_go <= 1'b0;
         addr_word_bit <= 1'b0;
         instr_go <= c == 2 || c == 3;
         instr_request <= c == 2 || c == 3;
         @(negedge clk);
         check("d_ras", ras_strobe, c <= 3);
         check("d_pc1", precharge_first, c == 4 || c == 5);
         if (c == 1)
            check("latched", latched_word_bit, 1'b1);
         if (c == 2)
            check("d_gate", row_copy_and_output_gate, !we);
         if (c == 5)
            check("cas_hold", cas_strobe, !we);
      end
   endtask
   // A pending refresh blocks a data start; its last cycle starts precharge.
   task automatic t_refresh();
      @(posedge clk);
      refresh_busy <= 1'b1;
      data_go <= 1'b1;
      @(posedge clk);
      data_go <= 1'b0;
      refresh_last <= 1'b1;
      @(negedge clk);
      check("rf_block", ras_strobe, 1'b0);
      @(posedge clk);
      refresh_last <= 1'b0;
      refresh_busy <= 1'b0;
      @(negedge clk);
      check("rf_pc1", precharge_first, 1'b1);
      repeat (3) @(posedge clk);
   endtask
   // Main sequence: eight reset cycles, then each scenario in turn.
   initial
   begin
      t_reset();
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      check("rst_ras", ras_strobe, 1'b0);
      check("rst_bank", bank_select_bit, 1'b0);
      t_regs();
      t_addr();
      t_instr(1'b0);
      t_burst(1'b0);
      t_burst(1'b1);
      t_instr(1'b1);
      t_refresh();
      t_data(1'b0);
      t_data(1'b1);
      wrap_up();
   end
   // Watchdog at 10000 cycles, far beyond the under 100 cycles the scenarios need.
   initial
   begin
      #100000;
      miscompares++;
      wrap_up();
   end
endmodule // vdram_access_sequencer_tb_top

/* tb/vdram_far_side.sv */
// Far-side model: the delay line fed by an unloaded copy of the row strobe.
// Assumes one 100 MHz clock, so one tap step is 10 ns.
module vdram_far_side (
   input wire logic clk, // Processor clock.
   input wire logic rst_b, // Synchronous reset, active low.
   input wire logic ras_strobe, // Row strobe copy into the line.
   output logic delay_tap_short, // Strobe delayed by 90 ns.
   output logic delay_tap_long // Strobe delayed by 100 ns.
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] hist;
   // The line holds the strobe history; it is cleared so taps are known.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         hist <= 10'h000;
      else
         hist <= {hist[8:0], ras_strobe};
   end
   // Taps fire nine and ten edges after the strobe rises.
   assign delay_tap_short = hist[8];
   assign delay_tap_long = hist[9];
endmodule // vdram_far_side
